//--- shared/gel_pkg.sv
// Package with constants and types for the gateway error LED and ID select block
package gel_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned SYS_FLASH_PER_S = 2;
	localparam int unsigned PROTO_FLASH_PER_S = 1;
	localparam int unsigned WARN_HOLD_S     = 60;
	// Half period of each flash rate in clock cycles
	localparam int unsigned SYS_HALF_CYC    = CLK_HZ / (2 * SYS_FLASH_PER_S);
	localparam int unsigned PROTO_HALF_CYC  = CLK_HZ / (2 * PROTO_FLASH_PER_S);
	localparam int unsigned TICK_CYC        = CLK_HZ;

	// ----------------------------------------------------------------
	// Codes and IDs
	// ----------------------------------------------------------------
	localparam logic [3:0] CODE_NONE        = 4'h0;
	localparam logic [3:0] SERIOUS_MAX      = 4'h5;
	localparam logic [7:0] ID_TEST_MODE     = 8'hee;
	localparam logic [7:0] ID_CONFIG_MODE   = 8'hff;
	localparam logic [7:0] NODE_ID_USE_NVS  = 8'h00;
	localparam logic [7:0] NVS_NODE_ID_INIT = 8'h01;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		GEL_IDLE    = 2'b00,
		GEL_WARN    = 2'b01,
		GEL_SERIOUS = 2'b11
	} gel_disp_t;

	typedef enum logic [1:0]
	{
		GEL_MODE_RUN    = 2'b00,
		GEL_MODE_TEST   = 2'b01,
		GEL_MODE_CONFIG = 2'b11
	} gel_mode_t;

	typedef struct packed
	{
		logic       valid;
		logic       proto;
		logic [3:0] code;
	} gel_err_t;

	typedef struct packed
	{
		logic [3:0] weight;
		logic       state_red;
	} gel_led_t;

	typedef struct packed
	{
		gel_disp_t  disp;
		logic       proto;
		logic [3:0] code;
		logic [31:0] hold_s;
		logic [31:0] tick;
		logic [31:0] flash_cnt;
		logic       flash_ph;
		logic [1:0] boot;
		gel_mode_t  mode;
		logic [7:0] serial_id;
		logic [7:0] node_id;
		logic [7:0] sw_s1;
		logic [7:0] sw_s2;
		logic [7:0] dip_s1;
		logic [7:0] dip_s2;
		gel_led_t   led;
	} gel_state_t;

endpackage

//--- hw/gel_top.sv
// Error LED display and power-on ID selection for the serial to fieldbus gateway
// Operation
// - Error drives state red, code in binary
// - System codes one to five latch until power
// - System codes six to fifteen clear after minute
// - Serious system codes one to five
// - Warning system codes six to fifteen
// - System codes flash two times per second
// - Protocol codes flash once per second
// - Protocol codes clear after warning hold
// - Protocol code numbers passed through unchanged
// - Script may drive code LEDs directly
// - Config mode patterns carry no meaning
// - Serial ID from two rotaries at power-on
// - EE selects test, FF selects config
// - DIP node ID zero uses stored ID
// - Stored node ID defaults to one
// - State LED steady red error, flashing modes
`timescale 1ns/1ps
`default_nettype none

module gel_top
#(
	parameter int unsigned TICK_CYC       = gel_pkg::TICK_CYC,
	parameter int unsigned SYS_HALF_CYC   = gel_pkg::SYS_HALF_CYC,
	parameter int unsigned PROTO_HALF_CYC = gel_pkg::PROTO_HALF_CYC
)
(
	input  wire logic            clk_i,
	input  wire logic            rst_b_i,
	input  wire gel_pkg::gel_err_t err_i,
	input  wire logic [31:0]     warn_hold_s_i,
	input  wire logic            script_led_en_i,
	input  wire logic [3:0]      script_led_i,
	input  wire logic [3:0]      id_high_rotary_i,
	input  wire logic [3:0]      id_low_rotary_i,
	input  wire logic [7:0]      dip_node_id_i,
	input  wire logic [7:0]      nonvolatile_store_node_id_i,
	output logic                 code_led_weight_one_o,
	output logic                 code_led_weight_two_o,
	output logic                 code_led_weight_four_o,
	output logic                 code_led_weight_eight_o,
	output logic                 state_led_red_o,
	output logic [7:0]           serial_id_o,
	output logic [7:0]           node_id_o,
	output logic                 test_mode_o,
	output logic                 config_mode_o,
	output logic                 ids_valid_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	gel_pkg::gel_state_t st_ff;
	gel_pkg::gel_state_t nxt_st;
	logic                take_rep;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// A report is taken unless it is empty or a serious error is latched
	function automatic logic takes_report(
		input gel_pkg::gel_err_t  err,
		input gel_pkg::gel_disp_t disp
	);
		takes_report = err.valid && (err.code != gel_pkg::CODE_NONE)
			&& (disp != gel_pkg::GEL_SERIOUS);
	endfunction

	function automatic logic is_serious(input logic [3:0] code, input logic proto);
		is_serious = !proto && (code != gel_pkg::CODE_NONE)
			&& (code <= gel_pkg::SERIOUS_MAX);
	endfunction

	// Protocol reports keep the user hold; system warnings a fixed minute
	function automatic logic [31:0] hold_seconds(
		input logic        proto,
		input logic [31:0] user_hold
	);
		if (proto)
		begin
			hold_seconds = user_hold;
		end
		else
		begin
			hold_seconds = 32'(gel_pkg::WARN_HOLD_S);
		end
	endfunction

	// Last count of a flash half period; the rate follows the shown report
	function automatic logic [31:0] flash_last(input logic proto);
		if (proto)
		begin
			flash_last = 32'(PROTO_HALF_CYC - 1);
		end
		else
		begin
			flash_last = 32'(SYS_HALF_CYC - 1);
		end
	endfunction

	function automatic gel_pkg::gel_mode_t decode_mode(input logic [7:0] id);
		if (id == gel_pkg::ID_CONFIG_MODE)
		begin
			decode_mode = gel_pkg::GEL_MODE_CONFIG;
		end
		else if (id == gel_pkg::ID_TEST_MODE)
		begin
			decode_mode = gel_pkg::GEL_MODE_TEST;
		end
		else
		begin
			// Reserved setting DD is not decoded here; operator must avoid it
			decode_mode = gel_pkg::GEL_MODE_RUN;
		end
	endfunction

	// A zero DIP field falls back to the stored ID, which also reaches past 63
	function automatic logic [7:0] pick_node_id(
		input logic [7:0] dip,
		input logic [7:0] stored
	);
		if (dip == gel_pkg::NODE_ID_USE_NVS)
		begin
			pick_node_id = stored;
		end
		else
		begin
			pick_node_id = dip;
		end
	endfunction

	// Script wins over the error display; the off phase blanks the code
	function automatic logic [3:0] code_pattern(
		input logic               script_en,
		input logic [3:0]         script,
		input gel_pkg::gel_disp_t disp,
		input logic               on_phase,
		input logic [3:0]         code
	);
		if (script_en)
		begin
			code_pattern = script;
		end
		else if ((disp != gel_pkg::GEL_IDLE) && on_phase)
		begin
			code_pattern = code;
		end
		else
		begin
			code_pattern = 4'h0;
		end
	endfunction

	// Modes flash the state LED; otherwise it lights steadily while a code shows
	function automatic logic state_pattern(
		input gel_pkg::gel_mode_t mode,
		input gel_pkg::gel_disp_t disp,
		input logic               on_phase
	);
		if (mode != gel_pkg::GEL_MODE_RUN)
		begin
			state_pattern = on_phase;
		end
		else
		begin
			state_pattern = (disp != gel_pkg::GEL_IDLE);
		end
	endfunction

	// ----------------------------------------------------------------
	// Report acceptance
	// ----------------------------------------------------------------
	assign take_rep = takes_report(err_i, st_ff.disp);

	always_comb
	begin
		nxt_st = st_ff;

		// ----------------------------------------------------------------
		// Power-on sampling of switches
		// ----------------------------------------------------------------
		// Switch pins pass two flops before use
		nxt_st.sw_s1  = {id_high_rotary_i, id_low_rotary_i};
		nxt_st.sw_s2  = st_ff.sw_s1;
		nxt_st.dip_s1 = dip_node_id_i;
		nxt_st.dip_s2 = st_ff.dip_s1;
		if (st_ff.boot != 2'h3)
		begin
			nxt_st.boot = st_ff.boot + 2'h1;
		end
		// Latched once, on the third clock edge after release, when the sync chain is full
		if (st_ff.boot == 2'h2)
		begin
			nxt_st.serial_id = st_ff.sw_s2;
			nxt_st.mode      = decode_mode(st_ff.sw_s2);
			nxt_st.node_id   = pick_node_id(st_ff.dip_s2, nonvolatile_store_node_id_i);
		end

		// ----------------------------------------------------------------
		// Seconds tick and hold countdown
		// ----------------------------------------------------------------
		if (st_ff.tick >= TICK_CYC - 1)
		begin
			nxt_st.tick = '0;
			if (st_ff.disp == gel_pkg::GEL_WARN)
			begin
				if (st_ff.hold_s <= 32'h1)
				begin
					nxt_st.disp = gel_pkg::GEL_IDLE;
					nxt_st.code = gel_pkg::CODE_NONE;
					nxt_st.proto = 1'b0;
				end
				else
				begin
					nxt_st.hold_s = st_ff.hold_s - 32'h1;
				end
			end
		end
		else
		begin
			nxt_st.tick = st_ff.tick + 32'h1;
		end

		// ----------------------------------------------------------------
		// Error capture
		// ----------------------------------------------------------------
		// Serious state only leaves through reset
		if (take_rep)
		begin
			nxt_st.code      = err_i.code;
			nxt_st.proto     = err_i.proto;
			nxt_st.tick      = '0;
			nxt_st.flash_cnt = '0;
			nxt_st.flash_ph  = 1'b1;
			if (is_serious(err_i.code, err_i.proto))
			begin
				nxt_st.disp = gel_pkg::GEL_SERIOUS;
			end
			else
			begin
				nxt_st.disp   = gel_pkg::GEL_WARN;
				nxt_st.hold_s = hold_seconds(err_i.proto, warn_hold_s_i);
			end
		end

		// ----------------------------------------------------------------
		// Flash generator
		// ----------------------------------------------------------------
		// A taken report restarts the on phase, so a wrap must not flip it back
		if (!take_rep)
		begin
			if (st_ff.flash_cnt >= flash_last(st_ff.proto))
			begin
				nxt_st.flash_cnt = '0;
				nxt_st.flash_ph  = ~st_ff.flash_ph;
			end
			else
			begin
				nxt_st.flash_cnt = st_ff.flash_cnt + 32'h1;
			end
		end

		// ----------------------------------------------------------------
		// LED outputs
		// ----------------------------------------------------------------
		// Config mode patterns are not an error encoding
		nxt_st.led.weight    = code_pattern(script_led_en_i, script_led_i, st_ff.disp,
			st_ff.flash_ph, st_ff.code);
		nxt_st.led.state_red = state_pattern(st_ff.mode, st_ff.disp, st_ff.flash_ph);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign code_led_weight_one_o   = st_ff.led.weight[0];
	assign code_led_weight_two_o   = st_ff.led.weight[1];
	assign code_led_weight_four_o  = st_ff.led.weight[2];
	assign code_led_weight_eight_o = st_ff.led.weight[3];
	assign state_led_red_o         = st_ff.led.state_red;
	assign serial_id_o             = st_ff.serial_id;
	assign node_id_o               = st_ff.node_id;
	assign test_mode_o             = (st_ff.mode == gel_pkg::GEL_MODE_TEST);
	assign config_mode_o           = (st_ff.mode == gel_pkg::GEL_MODE_CONFIG);
	assign ids_valid_o             = (st_ff.boot == 2'h3);

endmodule

`default_nettype wire

//--- bench/gel_panel.sv
// Model of the front panel: rotary and DIP switches, stored node ID, code LEDs
`timescale 1ns/1ps
`default_nettype none
module gel_panel
(
	input  wire logic [7:0] rot_set_i,
	input  wire logic [7:0] dip_set_i,
	input  wire logic [3:0] led_i,
	output logic [3:0]      hi_o,
	output logic [3:0]      lo_o,
	output logic [7:0]      dip_o,
	output logic [7:0]      nvs_o,
	output logic [3:0]      code_o
);
	// Switches move only while the unit is held in reset; reserved setting unused
	assign {hi_o, lo_o} = rot_set_i;
	assign dip_o = dip_set_i;
	assign nvs_o = gel_pkg::NVS_NODE_ID_INIT;
	assign code_o = led_i;
endmodule
`default_nettype wire

//--- bench/gel_assertions.sv
// Concurrent checks on the ports of the error LED and ID select block
`timescale 1ns/1ps
`default_nettype none
module gel_checker
(
	input wire logic              clk_i,
	input wire logic              rst_b_i,
	input wire gel_pkg::gel_err_t err_i,
	input wire logic              script_led_en_i,
	input wire logic [3:0]        script_led_i,
	input wire logic [3:0]        id_high_rotary_i,
	input wire logic [3:0]        id_low_rotary_i,
	input wire logic [7:0]        dip_node_id_i,
	input wire logic [7:0]        nonvolatile_store_node_id_i,
	input wire logic              code_led_weight_one_o,
	input wire logic              code_led_weight_two_o,
	input wire logic              code_led_weight_four_o,
	input wire logic              code_led_weight_eight_o,
	input wire logic              state_led_red_o,
	input wire logic [7:0]        serial_id_o,
	input wire logic [7:0]        node_id_o,
	input wire logic              test_mode_o,
	input wire logic              config_mode_o,
	input wire logic              ids_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic [3:0] led_w = {code_led_weight_eight_o, code_led_weight_four_o,
		code_led_weight_two_o, code_led_weight_one_o};
	wire logic take_w = err_i.valid && err_i.code != 4'h0 && !test_mode_o && !config_mode_o;
	logic ser_ff;
	// Set once a serious report was seen outside test and config modes; only a reset may clear the display
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			ser_ff <= 1'b0;
		else if (take_w && !err_i.proto && err_i.code <= 4'h5)
			ser_ff <= 1'b1;

	AST_RED_ON: assert property (take_w |-> ##2 state_led_red_o) else $error("red late");
	AST_CODE_SHOWN: assert property (take_w && !ser_ff && !script_led_en_i &&
		!$past(err_i.valid) ##1 !err_i.valid && !script_led_en_i ##1 !script_led_en_i
		|-> led_w == $past(err_i.code, 2)) else $error("code wrong");
	AST_SERIOUS_HELD: assert property (ser_ff && $past(ser_ff) |-> state_led_red_o)
		else $error("serious cleared");
	AST_SCRIPT_DIRECT: assert property (script_led_en_i |=> led_w == $past(script_led_i))
		else $error("script leds");
	AST_IDS_FROZEN: assert property (ids_valid_o |=> ids_valid_o && $stable(serial_id_o) &&
		$stable(node_id_o)) else $error("ids moved");
	AST_SERIAL_ID: assert property (ids_valid_o |->
		serial_id_o == {id_high_rotary_i, id_low_rotary_i}) else $error("serial id");
	AST_MODE_DECODE: assert property (ids_valid_o |-> test_mode_o == (serial_id_o == 8'hee) &&
		config_mode_o == (serial_id_o == 8'hff)) else $error("mode decode");
	AST_NODE_SELECT: assert property (ids_valid_o |-> node_id_o == ((dip_node_id_i == 8'h00) ?
		nonvolatile_store_node_id_i : dip_node_id_i)) else $error("node id");
	cover property (ser_ff);
	cover property (take_w && err_i.proto);
	cover property (script_led_en_i && ids_valid_o);
	cover property (test_mode_o && state_led_red_o);
endmodule
bind gel_top gel_checker i_gel_checker (
	.clk_i                       (clk_i),
	.rst_b_i                     (rst_b_i),
	.err_i                       (err_i),
	.script_led_en_i             (script_led_en_i),
	.script_led_i                (script_led_i),
	.id_high_rotary_i            (id_high_rotary_i),
	.id_low_rotary_i             (id_low_rotary_i),
	.dip_node_id_i               (dip_node_id_i),
	.nonvolatile_store_node_id_i (nonvolatile_store_node_id_i),
	.code_led_weight_one_o       (code_led_weight_one_o),
	.code_led_weight_two_o       (code_led_weight_two_o),
	.code_led_weight_four_o      (code_led_weight_four_o),
	.code_led_weight_eight_o     (code_led_weight_eight_o),
	.state_led_red_o             (state_led_red_o),
	.serial_id_o                 (serial_id_o),
	.node_id_o                   (node_id_o),
	.test_mode_o                 (test_mode_o),
	.config_mode_o               (config_mode_o),
	.ids_valid_o                 (ids_valid_o)
);
`default_nettype wire

//--- bench/testbench.sv
// Directed testbench for the error LED and ID select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic              clk_i = 1'b0;
	logic              rst_b_i = 1'b0;
	gel_pkg::gel_err_t err_i = '0;
	logic [31:0]       warn_hold_s_i = 32'h2;
	logic              script_led_en_i = 1'b0;
	logic [3:0]        script_led_i = 4'h0;
	logic [3:0]        id_high_rotary_i, id_low_rotary_i, code;
	logic [7:0]        dip_node_id_i, nonvolatile_store_node_id_i, serial_id_o, node_id_o;
	logic              code_led_weight_one_o, code_led_weight_two_o, code_led_weight_four_o;
	logic              code_led_weight_eight_o, state_led_red_o;
	logic              test_mode_o, config_mode_o, ids_valid_o;
	logic [7:0]        rot_set = 8'h3c;
	logic [7:0]        dip_set = 8'h00;
	int                errors = 0;
	int                compares = 0;

	gel_top #(.TICK_CYC(20), .SYS_HALF_CYC(5), .PROTO_HALF_CYC(10)) i_gel_top (
		.clk_i                       (clk_i),
		.rst_b_i                     (rst_b_i),
		.err_i                       (err_i),
		.warn_hold_s_i               (warn_hold_s_i),
		.script_led_en_i             (script_led_en_i),
		.script_led_i                (script_led_i),
		.id_high_rotary_i            (id_high_rotary_i),
		.id_low_rotary_i             (id_low_rotary_i),
		.dip_node_id_i               (dip_node_id_i),
		.nonvolatile_store_node_id_i (nonvolatile_store_node_id_i),
		.code_led_weight_one_o       (code_led_weight_one_o),
		.code_led_weight_two_o       (code_led_weight_two_o),
		.code_led_weight_four_o      (code_led_weight_four_o),
		.code_led_weight_eight_o     (code_led_weight_eight_o),
		.state_led_red_o             (state_led_red_o),
		.serial_id_o                 (serial_id_o),
		.node_id_o                   (node_id_o),
		.test_mode_o                 (test_mode_o),
		.config_mode_o               (config_mode_o),
		.ids_valid_o                 (ids_valid_o)
	);
	gel_panel i_gel_panel (.rot_set_i(rot_set), .dip_set_i(dip_set),
		.led_i({code_led_weight_eight_o, code_led_weight_four_o,
		code_led_weight_two_o, code_led_weight_one_o}), .hi_o(id_high_rotary_i),
		.lo_o(id_low_rotary_i), .dip_o(dip_node_id_i), .nvs_o(nonvolatile_store_node_id_i),
		.code_o(code));

	always #2.5 clk_i = ~clk_i;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic report(input logic proto, input logic [3:0] c);
		err_i = '{valid: 1'b1, proto: proto, code: c};
		cyc(1);
		err_i = '0;
	endtask

	// Switches are only moved while power is off, as an operator would
	task automatic power_cycle(input logic [7:0] rot, input logic [7:0] dip);
		rst_b_i = 1'b0;
		rot_set = rot;
		dip_set = dip;
		cyc(6);
		rst_b_i = 1'b1;
		cyc(6);
	endtask

	task automatic print_verdict;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		power_cycle(8'h3c, 8'h00);
		chk("serial id", 8'h3c, serial_id_o);
		chk("node id", 8'h01, node_id_o);
		chk("modes", 8'h00, {6'h0, test_mode_o, config_mode_o});
		chk("ids valid", 8'h01, {7'h0, ids_valid_o});
		$display("test ids done");
		report(1'b0, 4'h7);
		cyc(2);
		chk("warn code", 8'h0f, {3'h0, code, state_led_red_o});
		cyc(5);
		chk("flash off", 8'h00, {4'h0, code});
		cyc(1187);
		chk("warn kept", 8'h01, {7'h0, state_led_red_o});
		cyc(8);
		chk("warn clear", 8'h00, {3'h0, code, state_led_red_o});
		$display("test warning done");
		report(1'b1, 4'h9);
		cyc(7);
		chk("proto code", 8'h09, {4'h0, code});
		report(1'b1, 4'he);
		cyc(2);
		chk("proto newest", 8'h0e, {4'h0, code});
		cyc(33);
		chk("proto restart", 8'h01, {7'h0, state_led_red_o});
		cyc(13);
		chk("proto clear", 8'h00, {3'h0, code, state_led_red_o});
		$display("test protocol done");
		script_led_en_i = 1'b1;
		script_led_i = 4'ha;
		cyc(1);
		chk("script", 8'h0a, {4'h0, code});
		script_led_en_i = 1'b0;
		$display("test script done");
		report(1'b0, 4'h2);
		cyc(5);
		// A warning after a serious error must be refused and leave its timing alone
		report(1'b0, 4'h8);
		cyc(1296);
		chk("serious held", 8'h05, {3'h0, code, state_led_red_o});
		$display("test serious done");
		power_cycle(8'hee, 8'h2a);
		chk("test id", 8'hee, serial_id_o);
		chk("test node", 8'h2a, node_id_o);
		chk("test modes", 8'h02, {6'h0, test_mode_o, config_mode_o});
		chk("test red on", 8'h01, {7'h0, state_led_red_o});
		cyc(5);
		chk("test red off", 8'h00, {7'h0, state_led_red_o});
		$display("test mode done");
		power_cycle(8'hff, 8'h00);
		chk("config modes", 8'h01, {6'h0, test_mode_o, config_mode_o});
		chk("config node", 8'h01, node_id_o);
		$display("test config done");
		print_verdict();
	end

	initial
	begin
		#40000;
		errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
